// *** include/smwl_defs.vh ***
// Constants shared by the shared-memory window lock design.
// Assumes an 8-bit Avalon-MM host port with byte addresses.
`ifndef SMWL_DEFS_VH
`define SMWL_DEFS_VH

// ------------------------------------------------------------
// Address map
// ------------------------------------------------------------
`define SMWL_AW          11
`define SMWL_WIN_MSB     10
`define SMWL_WIN_LSB     9
`define SMWL_WIN_PRI     2'b00
`define SMWL_WIN_SEC     2'b01
`define SMWL_REG_PRD     11'h400
`define SMWL_REG_PWR     11'h401
`define SMWL_REG_SRD     11'h402
`define SMWL_REG_SWR     11'h403
`define SMWL_REG_SA      11'h404
`define SMWL_REG_OWN     11'h405
`define SMWL_REG_CTRL    11'h406

// ------------------------------------------------------------
// Fields and values
// ------------------------------------------------------------
`define SMWL_CTRL_START  0
`define SMWL_CNT_MAX     4'h8
`define SMWL_CNT_ZERO    4'h0
`define SMWL_CNT_ONE     4'h1
`define SMWL_BLOCKS      7'h40
`define SMWL_WIDTH_ONE   7'h01
`define SMWL_RST_SA      6'h00
`define SMWL_RST_OWN     6'h00
`define SMWL_RST_CTRL    1'b0
`define SMWL_UNMAPPED    8'h00
`define SMWL_BLK_CLEAR   64'h0000000000000000
`define SMWL_MASK_NONE   8'h00
`define SMWL_BLK_FIRST   6'h00
`define SMWL_OWN_ZERO    6'h00
`define SMWL_DATA_NONE   8'h00

`endif

// *** rtl/smwl_owned_region.v ***
// Decides whether one memory block lies in the station's owned run.
// Assumes station address and width are stable register outputs.
module smwl_owned_region (
	input  wire [5:0] station_address,
	input  wire [5:0] own_width,
	input  wire [5:0] block,
	output wire       owned
);
`include "smwl_defs.vh"

	wire [6:0] width_eff;
	wire [6:0] run_end;

	// Zero width means one block
	assign width_eff = (own_width == `SMWL_OWN_ZERO) ? `SMWL_WIDTH_ONE : {1'b0, own_width};
	assign run_end   = {1'b0, station_address} + width_eff;
	// Block index never exceeds 63, so the run is clipped for free
	assign owned = ({1'b0, block} >= {1'b0, station_address}) &&
	               ({1'b0, block} < run_end);
endmodule // smwl_owned_region

// *** rtl/smwl_window_lock.v ***
// Read and write lock engine of one address window.
// Assumes at most one accepted access per cycle from the bus slave.
module smwl_window_lock (
	input  wire        clk,
	input  wire        rst,
	input  wire        rd_cnt_load,
	input  wire        wr_cnt_load,
	input  wire [7:0]  cnt_wdata,
	input  wire        acc_rd,
	input  wire        acc_wr,
	input  wire [8:0]  acc_addr,
	input  wire [7:0]  acc_wdata,
	input  wire [63:0] blk_data,
	output wire [3:0]  rd_cnt,
	output wire [3:0]  wr_cnt,
	output wire        rd_hit,
	output wire [7:0]  snap_byte,
	output wire        wr_locked,
	output wire        commit,
	output wire [5:0]  stage_blk,
	output reg  [63:0] stage_data,
	output reg  [7:0]  stage_mask
);
`include "smwl_defs.vh"

	reg [3:0]  rd_cnt_reg;
	reg [3:0]  wr_cnt_reg;
	reg        rd_first_reg;
	reg        wr_first_reg;
	reg [63:0] snap_reg;
	reg [63:0] stage_reg;
	reg [7:0]  mask_reg;
	reg [5:0]  blk_reg;

	// Larger counts saturate at the snapshot size
	function [3:0] sat_count;
		input [7:0] v;
		begin
			sat_count = (v > {4'h0, `SMWL_CNT_MAX}) ? `SMWL_CNT_MAX : v[3:0];
		end
	endfunction

	assign rd_cnt    = rd_cnt_reg;
	assign wr_cnt    = wr_cnt_reg;
	assign rd_hit    = (rd_cnt_reg != `SMWL_CNT_ZERO) && !rd_first_reg;
	assign snap_byte = snap_reg[{acc_addr[2:0], 3'b000} +: 8];
	assign wr_locked = (wr_cnt_reg != `SMWL_CNT_ZERO);
	assign commit    = acc_wr && (wr_cnt_reg == `SMWL_CNT_ONE);
	assign stage_blk = wr_first_reg ? acc_addr[8:3] : blk_reg;

	// Staged bytes merged with the closing write
	always @* begin
		stage_data = stage_reg;
		stage_mask = mask_reg;
		stage_data[{acc_addr[2:0], 3'b000} +: 8] = acc_wdata;
		stage_mask[acc_addr[2:0]] = 1'b1;
	end

	// Read and write halves share nothing
	always @(posedge clk) begin
		if (rst) begin
			rd_cnt_reg   <= `SMWL_CNT_ZERO;
			rd_first_reg <= 1'b0;
			snap_reg     <= `SMWL_BLK_CLEAR;
		end else if (rd_cnt_load && rd_cnt_reg == `SMWL_CNT_ZERO) begin
			rd_cnt_reg   <= sat_count(cnt_wdata);
			rd_first_reg <= (cnt_wdata != `SMWL_DATA_NONE);
		end else if (acc_rd && rd_cnt_reg != `SMWL_CNT_ZERO) begin
			rd_cnt_reg <= rd_cnt_reg - `SMWL_CNT_ONE;
			if (rd_first_reg) begin
				snap_reg     <= blk_data;
				rd_first_reg <= 1'b0;
			end
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			wr_cnt_reg   <= `SMWL_CNT_ZERO;
			wr_first_reg <= 1'b0;
			stage_reg    <= `SMWL_BLK_CLEAR;
			mask_reg     <= `SMWL_MASK_NONE;
			blk_reg      <= `SMWL_BLK_FIRST;
		end else if (wr_cnt_load && wr_cnt_reg == `SMWL_CNT_ZERO) begin
			wr_cnt_reg   <= sat_count(cnt_wdata);
			wr_first_reg <= 1'b1;
			mask_reg     <= `SMWL_MASK_NONE;
		end else if (acc_wr && wr_cnt_reg != `SMWL_CNT_ZERO) begin
			wr_cnt_reg   <= wr_cnt_reg - `SMWL_CNT_ONE;
			stage_reg    <= stage_data;
			mask_reg     <= stage_mask;
			blk_reg      <= stage_blk;
			wr_first_reg <= 1'b0;
		end
	end
endmodule // smwl_window_lock

// *** rtl/smwl_top.v ***
// Shared memory with two locked host windows and owned-region guard.
// Assumes an 8-bit Avalon-MM master and one synchronous reset.
// Operation
// - Memory is 512 bytes, sixty-four 8-byte blocks, block n for station n.
// - Owned run starts at station address and spans the ownership width.
// - Ownership width zero counts as one block.
// - Owned run is clipped at block 63.
// - Owned blocks always writable; others protected while network start is set.
// - Primary window maps the whole memory at 000h to 1FFh.
// - First locked read copies the whole block to snapshot, decrements count.
// - Later locked reads come from snapshot, decrement; zero unlocks.
// - Read lock count holds at most 8.
// - Locked writes go to staging buffer and decrement the count.
// - Write reaching zero commits all staged bytes at once and unlocks.
// - Read and write locks of a window are fully independent.
// - Locked read outside the block returns snapshot byte at low offset.
// - Locked write outside the block stages at its low offset.
// - Secondary window maps the same memory at 200h to 3FFh.
// - Secondary window has its own identical lock counts and buffers.
// - Secondary locks never touch primary locks, and vice versa.
// - Any primary read during a read lock uses snapshot and a count.
// - Nonzero count locks out further count writes until it reaches zero.
// - Count writes above 8 saturate to 8.
module smwl_top #(
	parameter MEM_BYTES = 512,
	parameter BLK_BYTES = 8
) (
	input  wire        clk,
	input  wire        rst,
	input  wire [10:0] avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [7:0]  avs_writedata,
	output wire [7:0]  avs_readdata,
	output wire        avs_waitrequest
);
`include "smwl_defs.vh"

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Full compare, so register aliases stay unmapped
	function reg_hit;
		input [10:0] addr;
		input [10:0] slot;
		begin
			reg_hit = (addr == slot);
		end
	endfunction

	function win_hit;
		input [10:0] addr;
		input [1:0]  win;
		begin
			win_hit = (addr[`SMWL_WIN_MSB:`SMWL_WIN_LSB] == win);
		end
	endfunction

	function [7:0] cnt_byte;
		input [3:0] cnt;
		begin
			cnt_byte = {4'h0, cnt};
		end
	endfunction

	function [7:0] cfg_byte;
		input [5:0] val;
		begin
			cfg_byte = {2'b00, val};
		end
	endfunction

	// ------------------------------------------------------------
	// Bus handshake
	// ------------------------------------------------------------
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_ACK  = 2'b10;

	reg  [1:0]  state_reg;
	reg  [1:0]  state_next;
	reg  [7:0]  rdata_reg;
	reg  [7:0]  rdata_next;
	wire        req;
	wire        accept;

	assign req             = avs_read | avs_write;
	assign accept          = req & state_reg[1];
	assign avs_waitrequest = req & ~state_reg[1];
	assign avs_readdata    = rdata_reg;

	// One wait cycle gives the read path a registered answer
	always @* begin
		case (state_reg)
			ST_IDLE: begin
				state_next = req ? ST_ACK : ST_IDLE;
			end
			ST_ACK: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always @(posedge clk) begin
		if (rst) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	wire        in_pri;
	wire        in_sec;
	wire [8:0]  mem_addr;
	wire        sel_prd;
	wire        sel_pwr;
	wire        sel_srd;
	wire        sel_swr;
	wire        sel_sa;
	wire        sel_own;
	wire        sel_ctrl;

	assign in_pri   = win_hit(avs_address, `SMWL_WIN_PRI);
	assign in_sec   = win_hit(avs_address, `SMWL_WIN_SEC);
	assign mem_addr = avs_address[8:0];
	assign sel_prd  = reg_hit(avs_address, `SMWL_REG_PRD);
	assign sel_pwr  = reg_hit(avs_address, `SMWL_REG_PWR);
	assign sel_srd  = reg_hit(avs_address, `SMWL_REG_SRD);
	assign sel_swr  = reg_hit(avs_address, `SMWL_REG_SWR);
	assign sel_sa   = reg_hit(avs_address, `SMWL_REG_SA);
	assign sel_own  = reg_hit(avs_address, `SMWL_REG_OWN);
	assign sel_ctrl = reg_hit(avs_address, `SMWL_REG_CTRL);

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	reg  [5:0]  station_address_reg;
	reg  [5:0]  own_width_reg;
	reg         start_reg;
	wire        wr_acc;
	wire        rd_acc;

	assign wr_acc = accept & avs_write;
	assign rd_acc = accept & avs_read;

	always @(posedge clk) begin
		if (rst) begin
			station_address_reg <= `SMWL_RST_SA;
			own_width_reg       <= `SMWL_RST_OWN;
			start_reg           <= `SMWL_RST_CTRL;
		end else if (wr_acc) begin
			if (sel_sa) begin
				station_address_reg <= avs_writedata[5:0];
			end
			if (sel_own) begin
				own_width_reg <= avs_writedata[5:0];
			end
			if (sel_ctrl) begin
				start_reg <= avs_writedata[`SMWL_CTRL_START];
			end
		end
	end

	// ------------------------------------------------------------
	// Shared memory
	// ------------------------------------------------------------
	reg  [7:0]  mem [0:MEM_BYTES-1];
	reg  [63:0] blk_data;
	integer     b;

	// Whole block view feeds the snapshot copy
	always @* begin
		blk_data = `SMWL_BLK_CLEAR;
		for (b = 0; b < BLK_BYTES; b = b + 1) begin
			blk_data[b*8 +: 8] = mem[{mem_addr[8:3], b[2:0]}];
		end
	end

	// ------------------------------------------------------------
	// Window lock engines
	// ------------------------------------------------------------
	wire [3:0]  p_rd_cnt;
	wire [3:0]  p_wr_cnt;
	wire        p_rd_hit;
	wire [7:0]  p_snap;
	wire        p_wr_lock;
	wire        p_commit;
	wire [5:0]  p_blk;
	wire [63:0] p_data;
	wire [7:0]  p_mask;
	wire [3:0]  s_rd_cnt;
	wire [3:0]  s_wr_cnt;
	wire        s_rd_hit;
	wire [7:0]  s_snap;
	wire        s_wr_lock;
	wire        s_commit;
	wire [5:0]  s_blk;
	wire [63:0] s_data;
	wire [7:0]  s_mask;

	smwl_window_lock u_pri (
		.clk         (clk),
		.rst         (rst),
		.rd_cnt_load (wr_acc & sel_prd),
		.wr_cnt_load (wr_acc & sel_pwr),
		.cnt_wdata   (avs_writedata),
		.acc_rd      (rd_acc & in_pri),
		.acc_wr      (wr_acc & in_pri),
		.acc_addr    (mem_addr),
		.acc_wdata   (avs_writedata),
		.blk_data    (blk_data),
		.rd_cnt      (p_rd_cnt),
		.wr_cnt      (p_wr_cnt),
		.rd_hit      (p_rd_hit),
		.snap_byte   (p_snap),
		.wr_locked   (p_wr_lock),
		.commit      (p_commit),
		.stage_blk   (p_blk),
		.stage_data  (p_data),
		.stage_mask  (p_mask)
	);

	// Separate instance keeps interrupt-side traffic out of the primary lock
	smwl_window_lock u_sec (
		.clk         (clk),
		.rst         (rst),
		.rd_cnt_load (wr_acc & sel_srd),
		.wr_cnt_load (wr_acc & sel_swr),
		.cnt_wdata   (avs_writedata),
		.acc_rd      (rd_acc & in_sec),
		.acc_wr      (wr_acc & in_sec),
		.acc_addr    (mem_addr),
		.acc_wdata   (avs_writedata),
		.blk_data    (blk_data),
		.rd_cnt      (s_rd_cnt),
		.wr_cnt      (s_wr_cnt),
		.rd_hit      (s_rd_hit),
		.snap_byte   (s_snap),
		.wr_locked   (s_wr_lock),
		.commit      (s_commit),
		.stage_blk   (s_blk),
		.stage_data  (s_data),
		.stage_mask  (s_mask)
	);

	// ------------------------------------------------------------
	// Owned-region guard
	// ------------------------------------------------------------
	wire        acc_owned;
	wire        cmt_owned;
	wire [5:0]  cmt_blk;
	wire [63:0] cmt_data;
	wire [7:0]  cmt_mask;
	wire        acc_ok;
	wire        cmt_ok;

	assign cmt_blk  = p_commit ? p_blk : s_blk;
	assign cmt_data = p_commit ? p_data : s_data;
	assign cmt_mask = p_commit ? p_mask : s_mask;

	smwl_owned_region u_own_acc (
		.station_address (station_address_reg),
		.own_width       (own_width_reg),
		.block           (mem_addr[8:3]),
		.owned           (acc_owned)
	);

	smwl_owned_region u_own_cmt (
		.station_address (station_address_reg),
		.own_width       (own_width_reg),
		.block           (cmt_blk),
		.owned           (cmt_owned)
	);

	assign acc_ok = acc_owned | ~start_reg;
	assign cmt_ok = cmt_owned | ~start_reg;

	// ------------------------------------------------------------
	// Memory write path
	// ------------------------------------------------------------
	wire        direct_wr;
	integer     k;

	// Unlocked write goes straight to memory
	assign direct_wr = wr_acc & ((in_pri & ~p_wr_lock) | (in_sec & ~s_wr_lock)) & acc_ok;

	// Commit lands in one clock so no peer sees a half update
	always @(posedge clk) begin
		if ((p_commit | s_commit) & cmt_ok) begin
			for (k = 0; k < BLK_BYTES; k = k + 1) begin
				if (cmt_mask[k]) begin
					mem[{cmt_blk, k[2:0]}] <= cmt_data[k*8 +: 8];
				end
			end
		end else if (direct_wr) begin
			mem[mem_addr] <= avs_writedata;
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	always @* begin
		rdata_next = `SMWL_UNMAPPED;
		if (in_pri) begin
			rdata_next = p_rd_hit ? p_snap : mem[mem_addr];
		end else if (in_sec) begin
			rdata_next = s_rd_hit ? s_snap : mem[mem_addr];
		end else if (sel_prd) begin
			rdata_next = cnt_byte(p_rd_cnt);
		end else if (sel_pwr) begin
			rdata_next = cnt_byte(p_wr_cnt);
		end else if (sel_srd) begin
			rdata_next = cnt_byte(s_rd_cnt);
		end else if (sel_swr) begin
			rdata_next = cnt_byte(s_wr_cnt);
		end else if (sel_sa) begin
			rdata_next = cfg_byte(station_address_reg);
		end else if (sel_own) begin
			rdata_next = cfg_byte(own_width_reg);
		end else if (sel_ctrl) begin
			rdata_next = {7'h00, start_reg};
		end
	end

	// Captured in the wait cycle; lock state cannot move before accept
	always @(posedge clk) begin
		if (rst) begin
			rdata_reg <= `SMWL_UNMAPPED;
		end else if (avs_read & state_reg[0]) begin
			rdata_reg <= rdata_next;
		end
	end
endmodule // smwl_top

// *** verif/smwl_chk.sv ***
// Bus timing and register field checks of smwl_top.
// Assumes binding to the ports of smwl_top.
module smwl_chk (
	input wire        clk,
	input wire        rst,
	input wire [10:0] avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [7:0]  avs_writedata,
	input wire [7:0]  avs_readdata,
	input wire        avs_waitrequest
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Properties
	// ----
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire req = avs_read | avs_write;
	wire rd_ok = avs_read & ~avs_waitrequest;
	chk_first_wait: assert property (req && !$past(req) |-> avs_waitrequest) else $error("new request not held off");
	chk_one_wait: assert property (req && avs_waitrequest |=> !avs_waitrequest) else $error("wait longer than one cycle");
	chk_again_wait: assert property (req && !avs_waitrequest |=> !req || avs_waitrequest) else $error("no wait on next");
	chk_idle_nowait: assert property (!req |-> !avs_waitrequest) else $error("wait while idle");
	// Capture only on a read, so idle cycles keep the last answer
	chk_rdata_hold: assert property (!req |=> $stable(avs_readdata)) else $error("read data moved while idle");
	chk_unmapped_zero: assert property (rd_ok && avs_address > 11'h406 |-> avs_readdata == 8'h00) else $error("unmapped");
	chk_count_max: assert property (rd_ok && avs_address inside {[11'h400:11'h403]} |-> avs_readdata <= 8'h08)
		else $error("count above eight");
	chk_station_bits: assert property (rd_ok && avs_address inside {11'h404, 11'h405} |-> avs_readdata[7:6] == 2'h0)
		else $error("station field too wide");
	chk_ctrl_bits: assert property (rd_ok && avs_address == 11'h406 |-> avs_readdata[7:1] == 7'h00)
		else $error("control upper bits set");
endmodule // smwl_chk

// *** verif/smwl_cpu_model.sv ***
// Host CPU model: Avalon-MM master with a blocking transfer task.
// Assumes the task is entered at a rising clock edge.
module smwl_cpu_model (
	input  wire         clk,
	output logic [10:0] avs_address,
	output logic        avs_read,
	output logic        avs_write,
	output logic [7:0]  avs_writedata,
	input  wire  [7:0]  avs_readdata,
	input  wire         avs_waitrequest
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Transfer
	// ----
	initial begin
		avs_address = 11'h000;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 8'h00;
	end
	// Gap zero gives back-to-back requests, larger gaps a slow host
	task automatic xfer(input logic wr, input logic [10:0] a, input logic [7:0] d, input int gap, output logic [7:0] q);
		avs_address <= a;
		avs_read <= ~wr;
		avs_write <= wr;
		avs_writedata <= d;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) @(posedge clk);
		q = avs_readdata;
		if (gap > 0) begin
			avs_read <= 1'b0;
			avs_write <= 1'b0;
			avs_writedata <= ~d;
			repeat (gap) @(posedge clk);
		end
	endtask
endmodule // smwl_cpu_model

// *** verif/tb_top.sv ***
// Self-checking bench of the shared-memory window lock block.
// Assumes the host model drives the bus and a bound checker.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Bench
	// ----
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [10:0] avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [7:0]  avs_writedata;
	logic [7:0]  avs_readdata;
	logic        avs_waitrequest;
	int          n_fail = 0;
	int          samples_checked = 0;
	logic [31:0] seed = 32'ha39d0153;
	logic [7:0]  mem [512];
	logic [7:0]  snap [2][8];
	logic [7:0]  stg [2][8];
	logic [7:0]  msk [2];
	logic [3:0]  rc [2] = '{4'h0, 4'h0};
	logic [3:0]  wc [2] = '{4'h0, 4'h0};
	logic        rf [2];
	logic        wf [2];
	logic [5:0]  wb [2];
	logic [5:0]  sa = 6'h00;
	logic [5:0]  own = 6'h00;
	logic        start = 1'b0;
	// One station's run per row; peers are assumed never to overlap it
	logic [7:0]  cfg [4][2] = '{'{8'h3e, 8'h03}, '{8'h05, 8'h00}, '{8'h20, 8'h3f}, '{8'h06, 8'h02}};
	always #50 clk = ~clk;
	smwl_top u_dut (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
	smwl_cpu_model u_cpu (.clk, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
	function automatic logic [31:0] nxt();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	function automatic logic okw(input logic [5:0] b);
		int n;
		n = (own == 6'h00) ? 1 : int'(own);
		return !start || (b >= sa && int'(b) < int'(sa) + n);
	endfunction
	task automatic check(input logic [10:0] a, input logic [7:0] s, input logic [7:0] x);
		samples_checked++;
		if (s !== x) begin
			n_fail++;
			$display("[ERR] readdata at %h exp %h seen %h", a, x, s);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Expectation is worked out before the transfer runs
	task automatic op(input logic wr, input logic [10:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic [7:0] e;
		int w;
		int o;
		int i;
		w = a[9];
		o = a[2:0];
		e = 8'h00;
		if (a < 11'h400) begin
			if (!wr && rc[w] != 4'h0) begin
				if (rf[w])
					for (i = 0; i < 8; i++) snap[w][i] = mem[{a[8:3], 3'(i)}];
				rf[w] = 1'b0;
				e = snap[w][o];
				rc[w]--;
			end else if (!wr)
				e = mem[a[8:0]];
			else if (wc[w] != 4'h0) begin
				if (wf[w])
					wb[w] = a[8:3];
				wf[w] = 1'b0;
				stg[w][o] = d;
				msk[w][o] = 1'b1;
				wc[w]--;
				if (wc[w] == 4'h0 && okw(wb[w]))
					for (i = 0; i < 8; i++) if (msk[w][i]) mem[{wb[w], 3'(i)}] = stg[w][i];
			end else if (okw(a[8:3]))
				mem[a[8:0]] = d;
		end else if (a < 11'h404) begin
			w = a[1];
			e = {4'h0, a[0] ? wc[w] : rc[w]};
			if (wr && !a[0] && rc[w] == 4'h0) begin
				rc[w] = (d > 8'h08) ? 4'h8 : d[3:0];
				rf[w] = 1'b1;
			end
			if (wr && a[0] && wc[w] == 4'h0) begin
				wc[w] = (d > 8'h08) ? 4'h8 : d[3:0];
				wf[w] = 1'b1;
				msk[w] = 8'h00;
			end
		end else if (a < 11'h407) begin
			if (wr && a == 11'h404) sa = d[5:0];
			if (wr && a == 11'h405) own = d[5:0];
			if (wr && a == 11'h406) start = d[0];
			e = (a == 11'h404) ? {2'h0, sa} : (a == 11'h405) ? {2'h0, own} : {7'h00, start};
		end
		u_cpu.xfer(wr, a, d, int'(nxt() % 3), q);
		if (!wr) check(a, q, e);
	endtask
	initial begin
		int i;
		int k;
		int w;
		logic [31:0] r;
		logic [10:0] ra;
		logic [10:0] wa;
		logic [10:0] oa;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (i = 0; i < 9; i++) op(1'b0, (i == 8) ? 11'h7ff : 11'h400 + 11'(i), 8'h00);
		for (i = 0; i < 512; i++) op(1'b1, {1'b0, seed[3], 9'(i)}, 8'(nxt() >> 8));
		for (k = 0; k < 4; k++) begin
			op(1'b1, 11'h404, cfg[k][0]);
			op(1'b1, 11'h405, cfg[k][1]);
			op(1'b1, 11'h406, 8'h01);
			for (i = 0; i < 64; i++) begin
				r = nxt();
				op(1'b1, {1'b0, r[9], 6'(i), r[2:0]}, r[23:16]);
				op(1'b0, {1'b0, ~r[9], 6'(i), r[2:0]}, 8'h00);
			end
		end
		op(1'b1, 11'h406, 8'h00);
		for (w = 0; w < 2; w++) begin
			ra = 11'h400 + 11'(2 * w);
			wa = 11'(w) << 9;
			oa = 11'(1 - w) << 9;
			op(1'b1, ra, 8'h0c);
			op(1'b0, ra, 8'h00);
			op(1'b1, ra, 8'h03);
			op(1'b0, ra, 8'h00);
			op(1'b0, wa | 11'h0a8, 8'h00);
			op(1'b1, oa | 11'h0ab, 8'h5a);
			for (i = 0; i < 8; i++) op(1'b0, wa | 11'(nxt() & 32'h1ff), 8'h00);
			op(1'b1, ra + 11'h001, 8'h03);
			op(1'b1, wa | 11'h132, 8'h11);
			op(1'b1, wa | 11'h0f5, 8'h22);
			op(1'b0, oa | 11'h132, 8'h00);
			op(1'b1, ra, 8'h02);
			op(1'b1, wa | 11'h137, 8'h33);
			for (i = 0; i < 8; i++) op(1'b0, oa | 11'h130 | 11'(i), 8'h00);
			op(1'b0, ra, 8'h00);
		end
		repeat (400) begin
			r = nxt();
			op(r[31], 11'(r[26:16] % 11'h40a), r[7:0]);
		end
		stop_test();
	end
	// Whole run needs about 4500 cycles
	initial begin
		repeat (60000) @(posedge clk);
		n_fail++;
		stop_test();
	end
endmodule // tb_top
bind smwl_top smwl_chk u_chk (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
	.avs_waitrequest);
